// [rtl/pwt_translator.sv]
// Two inbound windows with 32-page lookup tables feeding the fabric
//
// Notes on behaviour
// R1 - Size code steps double the window: 00 is 32K, 03 256K, 1F 64T.
// R2 - Each window is exactly 32 equal pages.
// R3 - Bits from page boundary plus five to 63 must match base.
// R4 - Five bits above the page offset index the table.
// R5 - Bits below the index pass through as page offset.
// R6 - Hits go to the fabric with table port and optional translation.
// R7 - Translation on: lower table word replaces low bits above offset.
// R8 - Translation on: upper table word replaces bits 63:32.
// R9 - Replaced bits follow the size code; only offset bits kept.
// R10 - Four-bit port select routes the page; 0100 is memory controller.
// R11 - Windows read as prefetchable 64-bit memory, type 2.
// R12 - Translation off: address forwarded unchanged, table picks port.
// R13 - Base writes ignored until that window's enable bit is written high.
// R14 - Base bits 31:15 plus upper base compare with the bus address.
// R15 - Misses are not claimed and read no table entry.
`timescale 1ns/1ps
module pwt_translator (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rstn,
    // Register port
    input  wire logic [11:0]      reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    // Bus side request
    input  wire pwt_pkg::pwt_req_t bus_req,
    output logic                  bus_claim,
    // Fabric side
    output pwt_pkg::pwt_fab_t     fab_out
);
    import pwt_pkg::*;

    // Per-window control
    logic [31:0] size_ctrl_r;
    logic [1:0]  en_written_r;
    logic [31:0] base_lo_r [2];
    logic [31:0] base_hi_r [2];
    // Lookup tables: [window][page]
    logic [31:0] lut_lo_r [2][NUM_PAGES];
    logic [31:0] lut_hi_r [2][NUM_PAGES];
    logic [31:0] reg_rdata_r;
    logic        bus_claim_r;
    pwt_fab_t    fab_r;
    logic [15:0] hit_count_r;

    function automatic logic [31:0] base_view(input logic [31:0] b);
        // Attribute bits are fixed, low bits read zero
        base_view = {b[31:BASE_LSB], 11'h000, BASE_PREFETCH,
                     BASE_TYPE_64, BASE_IO_MODE}; // R11
    endfunction : base_view

    // Settings per window
    wire [4:0] size_w [2];
    wire [1:0] en_w;
    wire [1:0] notran_w;
    assign size_w[0]   = size_ctrl_r[W0_SIZE_LSB +: 5];
    assign size_w[1]   = size_ctrl_r[W1_SIZE_LSB +: 5];
    assign en_w[0]     = size_ctrl_r[W0_EN_BIT];
    assign en_w[1]     = size_ctrl_r[W1_EN_BIT];
    assign notran_w[0] = size_ctrl_r[W0_NOTRAN_BIT];
    assign notran_w[1] = size_ctrl_r[W1_NOTRAN_BIT];

    // Address decode
    wire       sel_lut   = reg_addr >= OFS_LUT_BASE && reg_addr <= OFS_LUT_LAST;
    wire [11:0] lut_off  = reg_addr - OFS_LUT_BASE;
    // Table layout: window, then lower/upper half, then page word
    wire       lut_win   = lut_off[8];
    wire       lut_upper = lut_off[7];
    wire [4:0] lut_page  = lut_off[6:2];
    wire       wr_size   = reg_wr && reg_addr == OFS_SIZE_CTRL;
    wire       wr_blo0   = reg_wr && reg_addr == OFS_BASE_LO_W0 && en_written_r[0];
    wire       wr_bhi0   = reg_wr && reg_addr == OFS_BASE_HI_W0 && en_written_r[0];
    wire       wr_blo1   = reg_wr && reg_addr == OFS_BASE_LO_W1 && en_written_r[1];
    wire       wr_bhi1   = reg_wr && reg_addr == OFS_BASE_HI_W1 && en_written_r[1];
    wire       wr_lut    = reg_wr && sel_lut;

    // Window decoders
    wire [1:0]  hit_w;
    wire [4:0]  idx_w  [2];
    wire [63:0] xa_w   [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_win
            pwt_window_decode u_dec (
                .size_code (size_w[g]),
                .enable    (en_w[g] && bus_req.valid),
                .notran    (notran_w[g]),
                .base      ({base_hi_r[g], base_lo_r[g][31:BASE_LSB],
                             15'h0000}),
                .addr      (bus_req.addr),
                .lut_lo    (lut_lo_r[g][idx_w[g]]),
                .lut_hi    (lut_hi_r[g][idx_w[g]]),
                .hit       (hit_w[g]),
                .index     (idx_w[g]),
                .xlat_addr (xa_w[g])
            );
        end
    endgenerate

    // First window wins if both are set to overlap
    wire       hit_any = |hit_w;
    wire       win_sel = !hit_w[0];
    wire [4:0] idx_sel = idx_w[win_sel];
    wire [3:0] port_sel =
        lut_lo_r[win_sel][idx_sel][LUT_PORT_LSB +: PORT_W]; // R10

    pwt_fab_t fab_nxt;
    always_comb begin
        fab_nxt = '0;
        if (hit_any) begin // R15
            fab_nxt.valid  = 1'b1; // R6
            fab_nxt.window = win_sel;
            fab_nxt.index  = idx_sel;
            fab_nxt.port   = port_sel; // R10
            fab_nxt.addr   = xa_w[win_sel]; // R6
        end
    end

    // Read mux
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (sel_lut) begin
            rd_nxt = lut_upper ? lut_hi_r[lut_win][lut_page]
                               : lut_lo_r[lut_win][lut_page];
        end else begin
            case (reg_addr)
                OFS_SIZE_CTRL:   rd_nxt = size_ctrl_r;
                OFS_BASE_LO_W0:  rd_nxt = base_view(base_lo_r[0]);
                OFS_BASE_HI_W0:  rd_nxt = base_hi_r[0];
                OFS_BASE_LO_W1:  rd_nxt = base_view(base_lo_r[1]);
                OFS_BASE_HI_W1:  rd_nxt = base_hi_r[1];
                OFS_XLAT_STATUS: rd_nxt = {16'h0000, hit_count_r};
                default:         rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            size_ctrl_r  <= SIZE_CTRL_RST;
            en_written_r <= 2'b00;
        end else if (wr_size) begin
            size_ctrl_r  <= reg_wdata;
            // Enable must be written high to open the base registers
            en_written_r <= en_written_r |
                {reg_wdata[W1_EN_BIT], reg_wdata[W0_EN_BIT]}; // R13
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            base_lo_r[0] <= 32'h0000_0000;
            base_hi_r[0] <= 32'h0000_0000;
            base_lo_r[1] <= 32'h0000_0000;
            base_hi_r[1] <= 32'h0000_0000;
        end else begin
            if (wr_blo0) base_lo_r[0] <= reg_wdata; // R13 R14
            if (wr_bhi0) base_hi_r[0] <= reg_wdata; // R13 R14
            if (wr_blo1) base_lo_r[1] <= reg_wdata; // R13 R14
            if (wr_bhi1) base_hi_r[1] <= reg_wdata; // R13 R14
        end
    end

    // Tables have no reset; software loads them before enabling
    always_ff @(posedge mclk) begin
        if (wr_lut && !lut_upper) lut_lo_r[lut_win][lut_page] <= reg_wdata;
        if (wr_lut && lut_upper)  lut_hi_r[lut_win][lut_page] <= reg_wdata;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_r <= 32'h0000_0000;
            bus_claim_r <= 1'b0;
            fab_r       <= '0;
            hit_count_r <= 16'h0000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_nxt : 32'h0000_0000;
            bus_claim_r <= hit_any; // R15
            fab_r       <= fab_nxt;
            if (hit_any) hit_count_r <= hit_count_r + 16'h0001;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign bus_claim = bus_claim_r;
    assign fab_out   = fab_r;
endmodule : pwt_translator

// [rtl/pwt_pkg.sv]
// Package for the window page translator: register map, fields, carriers
package pwt_pkg;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_BASE_LO_W0  = 12'h018;
    localparam logic [11:0] OFS_BASE_HI_W0  = 12'h01c;
    localparam logic [11:0] OFS_BASE_LO_W1  = 12'h020;
    localparam logic [11:0] OFS_BASE_HI_W1  = 12'h024;
    localparam logic [11:0] OFS_SIZE_CTRL   = 12'h04c;
    localparam logic [11:0] OFS_LUT_BASE    = 12'h500;
    localparam logic [11:0] OFS_LUT_LAST    = 12'h6fc;
    localparam logic [11:0] OFS_XLAT_STATUS = 12'h700;
    // Window size control fields, one group per window
    localparam int W0_SIZE_LSB   = 11;
    localparam int W0_NOTRAN_BIT = 10;
    localparam int W0_EN_BIT     = 9;
    localparam int W1_SIZE_LSB   = 3;
    localparam int W1_NOTRAN_BIT = 2;
    localparam int W1_EN_BIT     = 1;
    localparam logic [31:0] SIZE_CTRL_RST = 32'h0000_0000;
    // Base register read-only attributes
    localparam logic [1:0] BASE_TYPE_64 = 2'h2;
    localparam logic       BASE_PREFETCH = 1'b1;
    localparam logic       BASE_IO_MODE  = 1'b0;
    localparam int         BASE_LSB      = 15;
    // Geometry
    localparam int PAGE_SHIFT_MIN = 10;
    localparam int IDX_W          = 5;
    localparam int NUM_PAGES      = 32;
    localparam int PORT_W         = 4;
    localparam logic [3:0] PORT_MEMCTL = 4'b0100;
    localparam int LUT_PORT_LSB   = 0;
    localparam logic [11:0] RD_UNMAPPED = 12'h000;

    typedef struct packed {
        logic        valid;
        logic [63:0] addr;
    } pwt_req_t;

    typedef struct packed {
        logic        valid;
        logic        window;
        logic [4:0]  index;
        logic [3:0]  port;
        logic [63:0] addr;
    } pwt_fab_t;
endpackage : pwt_pkg

// [rtl/pwt_window_decode.sv]
// One window: hit detection, page index and address translation
`timescale 1ns/1ps
module pwt_window_decode (
    // Window settings
    input  wire logic [4:0]  size_code,
    input  wire logic        enable,
    input  wire logic        notran,
    input  wire logic [63:0] base,
    // Bus address and table answer
    input  wire logic [63:0] addr,
    input  wire logic [31:0] lut_lo,
    input  wire logic [31:0] lut_hi,
    // Results
    output logic             hit,
    output logic [4:0]       index,
    output logic [63:0]      xlat_addr
);
    import pwt_pkg::*;

    // Page offset width grows by one per code step
    wire [5:0]  page_shift = 6'(PAGE_SHIFT_MIN) + {1'b0, size_code}; // R1 R2
    wire [5:0]  win_shift  = page_shift + 6'(IDX_W);
    wire [63:0] off_mask   = (64'h1 << page_shift) - 64'h1;          // R5
    wire [63:0] win_mask   = ~((64'h1 << win_shift) - 64'h1);        // R3
    wire [63:0] tbl_addr   = {lut_hi, lut_lo};

    // Base compare uses bits 31:15 and up; window mask drops the rest
    assign hit   = enable && (((addr ^ base) & win_mask) == 64'h0); // R3 R14 R15
    assign index = 5'(addr >> page_shift);                          // R4
    // Translation on: offset bits kept, every higher bit from the table
    assign xlat_addr = notran ? addr                                // R12
                     : (addr & off_mask) | (tbl_addr & ~off_mask); // R7 R8 R9
endmodule : pwt_window_decode

// [verif/pwt_translator_props.sv]
// Checker for the window page translator ports
`timescale 1ns/1ps
module pwt_translator_props (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rstn,
    // Register port
    input wire logic [11:0]       reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    // Bus and fabric
    input wire pwt_pkg::pwt_req_t bus_req,
    input wire logic              bus_claim,
    input wire pwt_pkg::pwt_fab_t fab_out
);
    import pwt_pkg::*;
    logic [31:0] sz_r;
    wire         w  = fab_out.window;
    wire [4:0]   cd = w ? sz_r[7:3] : sz_r[15:11];
    wire [5:0]   sh = 6'h0a + {1'b0, cd};
    wire [63:0]  mk = (64'h1 << sh) - 64'h1;
    wire         nt = w ? sz_r[2] : sz_r[10];
    wire         en = w ? sz_r[1] : sz_r[9];
    // Shadow copy; only valid while size writes stay apart from traffic
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn) sz_r <= 32'h0;
        else if (reg_wr && reg_addr == OFS_SIZE_CTRL) sz_r <= reg_wdata;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence base_rd_s;
        reg_rd && (reg_addr == OFS_BASE_LO_W0 || reg_addr == OFS_BASE_LO_W1);
    endsequence
    claim_fab_a: assert property (bus_claim == fab_out.valid)
        else $error("claim and fabric valid differ");
    miss_zero_a: assert property (!bus_claim |-> fab_out == '0)
        else $error("fabric output not zero on a miss");
    claim_cause_a: assert property (bus_claim |-> $past(bus_req.valid) && en)
        else $error("claim without request or enable");
    off_quiet_a: assert property (!$past(sz_r[9] || sz_r[1]) |-> !bus_claim)
        else $error("claim with both windows off");
    page_index_a: assert property (fab_out.valid |->
        fab_out.index == 5'($past(bus_req.addr) >> sh))
        else $error("page index wrong");
    offset_keep_a: assert property (fab_out.valid |->
        ((fab_out.addr ^ $past(bus_req.addr)) & mk) == 64'h0)
        else $error("page offset altered");
    no_xlat_a: assert property (fab_out.valid && nt |->
        fab_out.addr == $past(bus_req.addr))
        else $error("address changed with translation off");
    base_attr_a: assert property (base_rd_s |=> reg_rdata[3:0] == 4'hc)
        else $error("base attributes wrong");
endmodule : pwt_translator_props
bind pwt_translator pwt_translator_props u_pwt_translator_props (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_req(bus_req), .bus_claim(bus_claim), .fab_out(fab_out));

// [verif/pwt_initiator.sv]
// Bus initiator model issuing one request per go pulse
`timescale 1ns/1ps
module pwt_initiator (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Command from the bench
    input  wire logic         go,
    input  wire logic [63:0]  addr_in,
    // Request toward the translator
    output pwt_pkg::pwt_req_t bus_req
);
    import pwt_pkg::*;
    // Idle cycles invert the address so a stale value never looks valid
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn) bus_req <= '0;
        else if (go) bus_req <= {1'b1, addr_in};
        else bus_req <= {1'b0, ~bus_req.addr};
endmodule : pwt_initiator

// [verif/tb_pwt_translator.sv]
// Self-checking bench for the window page translator
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_pwt_translator;
    import pwt_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        go = 1'b0;
    logic [63:0] a_in = 64'h0;
    pwt_req_t    bus_req;
    logic        bus_claim;
    pwt_fab_t    fab_out;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [31:0] s = 32'h0001_430f;
    always #50 mclk = ~mclk;
    pwt_initiator u_pwt_initiator (.mclk(mclk), .rstn(rstn), .go(go),
        .addr_in(a_in), .bus_req(bus_req));
    pwt_translator u_pwt_translator (.mclk(mclk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req),
        .bus_claim(bus_claim), .fab_out(fab_out));
    function automatic logic [31:0] rnd();
        s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction : rnd
    function automatic pwt_fab_t exp_fab(input logic [63:0] a, input logic w,
        input logic [4:0] c, input logic nt, input logic [31:0] lo, hi);
        logic [5:0]  sh;
        logic [63:0] mk;
        sh = 6'h0a + {1'b0, c};
        mk = (64'h1 << sh) - 64'h1;
        return '{1'b1, w, 5'(a >> sh), lo[3:0],
            nt ? a : (({hi, lo} & ~mk) | (a & mk))};
    endfunction : exp_fab
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 `CHK("reg_rdata", e, reg_rdata)
    endtask : rd
    task automatic req(input logic [63:0] a, input pwt_fab_t e);
        @(posedge mclk);
        go <= 1'b1;
        a_in <= a;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        #1 `CHK("fab_out", e, fab_out)
        `CHK("bus_claim", e.valid, bus_claim)
    endtask : req
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        logic [63:0] a;
        logic [31:0] lo, hi, r;
        logic [4:0]  c;
        logic [5:0]  sh;
        logic        w, nt;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        rd(OFS_BASE_LO_W0, 32'h0000_000c);
        wr(OFS_BASE_LO_W1, 32'ha000_0000);
        rd(OFS_BASE_LO_W1, 32'h0000_000c);
        wr(OFS_SIZE_CTRL, 32'h0000_001a);
        wr(OFS_BASE_LO_W1, 32'ha000_0000);
        wr(OFS_BASE_HI_W1, 32'h0);
        rd(OFS_BASE_LO_W1, 32'ha000_000c);
        rd(12'h7fc, 32'h0);
        wr(12'h608, 32'he500_0004);
        wr(12'h688, 32'h0);
        req(64'ha000_4820, '{1'b1, 1'b1, 5'h02, 4'h4, 64'he500_0820});
        req(64'ha004_0000, '0);
        req(64'h1_a000_4820, '0);
        // Codes 00 and 1f first, then random codes and pages, windows alternating
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : r[4:0];
            w = i[0];
            nt = r[7];
            lo = rnd();
            hi = rnd();
            a = {rnd(), rnd()};
            sh = 6'h0a + {1'b0, c};
            wr(OFS_SIZE_CTRL, w ? 32'({c, nt, 2'h2}) : 32'({c, nt, 10'h200}));
            wr(w ? OFS_BASE_LO_W1 : OFS_BASE_LO_W0, a[31:0]);
            wr(w ? OFS_BASE_HI_W1 : OFS_BASE_HI_W0, a[63:32]);
            wr(12'h500 + 12'({w, 1'b0, 5'(a >> sh), 2'h0}), lo);
            wr(12'h500 + 12'({w, 1'b1, 5'(a >> sh), 2'h0}), hi);
            rd(12'h500 + 12'({w, 1'b1, 5'(a >> sh), 2'h0}), hi);
            rd(w ? OFS_BASE_HI_W1 : OFS_BASE_HI_W0, a[63:32]);
            req(a, exp_fab(a, w, c, nt, lo, hi));
            a[sh + 6'h05] = ~a[sh + 6'h05];
            req(a, '0);
        end
        // One hit from the worked example plus one per loop pass
        rd(OFS_XLAT_STATUS, 32'h0000_0011);
        report_and_stop();
    end
endmodule : tb_pwt_translator
